// file: pkg/ldmc_pkg.sv
package ldmc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Operating modes
   typedef enum logic [2:0] {
      MODE_STANDBY,
      MODE_PRESTBY,
      MODE_RESET,
      MODE_LIMP,
      MODE_ACTIVE
   } ldmc_mode_e;

   ////////////////////////////////////////////////////////////////////////
   // Clock and times
   localparam int CLK_PERIOD_NS     = 25;
   localparam int RESET_DWELL_NS    = 400;
   localparam int WAKE_HOLD_NS      = 100000;
   localparam int STBY_DELAY_NS     = 2000000;
   localparam int AUTORESTART_NS    = 10000000;
   localparam int RESET_DWELL_CYC   =
      (RESET_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_HOLD_CYC_DEF =
      (WAKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STBY_DELAY_CYC_DEF =
      (STBY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int AUTORESTART_CYC_DEF = AUTORESTART_NS / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////
   // Frame targets and field positions
   localparam logic [1:0] FR_CTRL1   = 2'h1;
   localparam logic [1:0] FR_CTRL2   = 2'h2;
   localparam logic [1:0] FR_CTRL3   = 2'h3;
   localparam int UNLOCK_BIT         = 1;
   localparam int ACTIVE_REQ_BIT     = 2;
   localparam int STANDBY_REQ_BIT    = 3;
   localparam int BUCK1_SEL_LSB      = 14;
   localparam int BUCK2_SEL_LSB      = 12;

   ////////////////////////////////////////////////////////////////////////
   // Buck source selection
   localparam logic [1:0] SEL_OFF    = 2'h0;
   localparam logic [1:0] SEL_PWM    = 2'h1;
   localparam logic [1:0] SEL_ON     = 2'h2;
   localparam logic [1:0] SEL_DIM    = 2'h3;
   localparam logic [1:0] BUCK1_SEL_RST = SEL_DIM;
   localparam logic [1:0] BUCK2_SEL_RST = SEL_OFF;

endpackage

// file: verilog/ldmc_mode_ctrl.sv
`timescale 1ns/100ps

module ldmc_mode_ctrl
   import ldmc_pkg::*;
#(
   parameter int CNT_W           = 24,
   parameter int DATA_W          = 24,
   parameter int WAKE_HOLD_CYC   = WAKE_HOLD_CYC_DEF,
   parameter int STBY_DELAY_CYC  = STBY_DELAY_CYC_DEF,
   parameter int AUTORESTART_CYC = AUTORESTART_CYC_DEF
) (
   // Core clock and reset
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   // Serial link side, link clock domain
   input  wire logic              link_clk,
   input  wire logic              frame_valid,
   input  wire logic [1:0]        frame_addr,
   input  wire logic [DATA_W-1:0] frame_data,
   output      logic              frame_busy_q,
   // Pins
   input  wire logic              chip_select_n,
   input  wire logic              dim_in,
   input  wire logic              serial_supply_uv,
   // Internal events, core clock domain
   input  wire logic              watchdog_fail,
   input  wire logic              func_error_evt,
   input  wire logic              pwm1_in,
   input  wire logic              pwm2_in,
   // Mode and status
   output      ldmc_mode_e        mode_q,
   output      logic              serial_active_q,
   output      logic              rail_above_por_q,
   output      logic              low_power_q,
   output      logic              regs_default_q,
   output      logic              functional_error_flag_q,
   output      logic [1:0]        buck1_sel_q,
   output      logic [1:0]        buck2_sel_q,
   // Buck enables
   output      logic              buck1_en_q,
   output      logic              buck2_en_q
);

   localparam logic [CNT_W-1:0] WAKE_LIM  = CNT_W'(WAKE_HOLD_CYC);
   localparam logic [CNT_W-1:0] STBY_LIM  = CNT_W'(STBY_DELAY_CYC);
   localparam logic [CNT_W-1:0] AR_LIM    = CNT_W'(AUTORESTART_CYC - 1);
   localparam logic [CNT_W-1:0] RST_LIM   = CNT_W'(RESET_DWELL_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

   function automatic logic buck_drive(
      input logic [1:0] sel,
      input logic       pwm,
      input logic       dim
   );
      logic on;
      on = 1'b0;
      unique case (sel)
         SEL_OFF: on = 1'b0;
         SEL_PWM: on = pwm;
         SEL_ON:  on = 1'b1;
         SEL_DIM: on = dim;
      endcase
      return on;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Link domain: frame capture and handshake

   logic              lrst_s1_q;
   logic              lrst_q;
   logic              tgl_l_q;
   logic [1:0]        fr_addr_l_q;
   logic [DATA_W-1:0] fr_data_l_q;
   logic              ack_l_s1_q;
   logic              ack_l_s2_q;
   logic              ack_c_q;

   always_ff @(posedge link_clk) begin
      lrst_s1_q <= sys_rst;
      lrst_q    <= lrst_s1_q;
   end

   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         tgl_l_q     <= 1'b0;
         fr_addr_l_q <= 2'h0;
         fr_data_l_q <= '0;
      end else if (frame_valid && !frame_busy_q) begin
         tgl_l_q     <= ~tgl_l_q;
         fr_addr_l_q <= frame_addr;
         fr_data_l_q <= frame_data;
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         ack_l_s1_q <= 1'b0;
         ack_l_s2_q <= 1'b0;
      end else begin
         ack_l_s1_q <= ack_c_q;
         ack_l_s2_q <= ack_l_s1_q;
      end
   end

   // Busy from capture until core acknowledge returns
   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         frame_busy_q <= 1'b0;
      end else if (frame_valid && !frame_busy_q) begin
         frame_busy_q <= 1'b1;
      end else begin
         frame_busy_q <= tgl_l_q ^ ack_l_s2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core domain: synchronisers

   logic tgl_s1_q;
   logic tgl_s2_q;
   logic csn_s1_q;
   logic csn_q;
   logic dim_s1_q;
   logic dim_q;
   logic uv_s1_q;
   logic uv_q;
   logic fr_new;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         ack_c_q  <= 1'b0;
      end else begin
         tgl_s1_q <= tgl_l_q;
         tgl_s2_q <= tgl_s1_q;
         ack_c_q  <= tgl_s2_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         csn_s1_q <= 1'b1;
         csn_q    <= 1'b1;
         dim_s1_q <= 1'b0;
         dim_q    <= 1'b0;
         uv_s1_q  <= 1'b0;
         uv_q     <= 1'b0;
      end else begin
         csn_s1_q <= chip_select_n;
         csn_q    <= csn_s1_q;
         dim_s1_q <= dim_in;
         dim_q    <= dim_s1_q;
         uv_s1_q  <= serial_supply_uv;
         uv_q     <= uv_s1_q;
      end
   end

   // Captured frame is stable while the toggle pair differs
   assign fr_new = tgl_s2_q ^ ack_c_q;

   ////////////////////////////////////////////////////////////////////////
   // Frame decode

   logic fr_ok;
   logic fr_ctrl1;
   logic fr_ctrl2;
   logic fr_ctrl3;
   logic req_act;
   logic req_stb;
   logic unlock_q;
   logic seq_ok;

   // Frames only count while the serial port is awake
   assign fr_ok    = fr_new && serial_active_q;
   assign fr_ctrl1 = fr_ok && (fr_addr_l_q == FR_CTRL1);
   assign fr_ctrl2 = fr_ok && (fr_addr_l_q == FR_CTRL2);
   assign fr_ctrl3 = fr_ok && (fr_addr_l_q == FR_CTRL3);
   assign req_act  = fr_data_l_q[ACTIVE_REQ_BIT];
   assign req_stb  = fr_data_l_q[STANDBY_REQ_BIT];
   assign seq_ok   = fr_ctrl2 && unlock_q;

   // Arm lasts exactly one following frame
   always_ff @(posedge core_clk) begin
      if (sys_rst || mode_q == MODE_RESET) begin
         unlock_q <= 1'b0;
      end else if (fr_ok) begin
         unlock_q <= fr_ctrl1 && fr_data_l_q[UNLOCK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timers

   logic             hold_cond;
   logic [CNT_W-1:0] hold_lim;
   logic [CNT_W-1:0] hold_cnt_q;
   logic             hold_done;
   logic [CNT_W-1:0] rst_cnt_q;
   logic [CNT_W-1:0] ar_cnt_q;
   logic             ar_tick;

   always_comb begin
      hold_cond = 1'b0;
      hold_lim  = WAKE_LIM;
      if (mode_q == MODE_STANDBY) begin
         hold_cond = dim_q || !csn_q;
      end else if (mode_q == MODE_PRESTBY) begin
         hold_cond = csn_q && !dim_q;
         hold_lim  = STBY_LIM;
      end
   end

   // Condition must stand for more than the limit
   assign hold_done = hold_cond && (hold_cnt_q >= hold_lim);

   always_ff @(posedge core_clk) begin
      if (sys_rst || !hold_cond || hold_done) begin
         hold_cnt_q <= '0;
      end else begin
         hold_cnt_q <= hold_cnt_q + CNT_ONE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst || mode_q != MODE_RESET) begin
         rst_cnt_q <= '0;
      end else begin
         rst_cnt_q <= rst_cnt_q + CNT_ONE;
      end
   end

   assign ar_tick = (ar_cnt_q == AR_LIM);

   always_ff @(posedge core_clk) begin
      if (sys_rst || mode_q != MODE_LIMP || ar_tick) begin
         ar_cnt_q <= '0;
      end else begin
         ar_cnt_q <= ar_cnt_q + CNT_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode machine

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mode_q <= MODE_STANDBY;
      end else begin
         unique case (mode_q)
            MODE_STANDBY: begin
               if (hold_done) begin
                  mode_q <= MODE_RESET;
               end
            end
            MODE_PRESTBY: begin
               if (hold_done) begin
                  mode_q <= MODE_STANDBY;
               end
            end
            MODE_RESET: begin
               if (rst_cnt_q == RST_LIM) begin
                  mode_q <= MODE_LIMP;
               end
            end
            MODE_LIMP: begin
               if (seq_ok && req_act && !req_stb) begin
                  mode_q <= MODE_ACTIVE;
               end else if (seq_ok && !req_act && req_stb) begin
                  mode_q <= MODE_PRESTBY;
               end
            end
            MODE_ACTIVE: begin
               if (uv_q || watchdog_fail) begin
                  mode_q <= MODE_RESET;
               end else if (fr_ctrl2 && !req_act && !req_stb) begin
                  mode_q <= MODE_RESET;
               end else if (seq_ok && req_act && req_stb) begin
                  mode_q <= MODE_RESET;
               end else if (seq_ok && !req_act && req_stb) begin
                  mode_q <= MODE_PRESTBY;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Buck source configuration

   always_ff @(posedge core_clk) begin
      if (sys_rst || mode_q == MODE_RESET) begin
         buck1_sel_q <= BUCK1_SEL_RST;
         buck2_sel_q <= BUCK2_SEL_RST;
      end else if (fr_ctrl3 && mode_q == MODE_ACTIVE) begin
         // Writes in Limp Home are taken and dropped
         buck1_sel_q <= fr_data_l_q[BUCK1_SEL_LSB +: 2];
         buck2_sel_q <= fr_data_l_q[BUCK2_SEL_LSB +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Functional error flag

   always_ff @(posedge core_clk) begin
      if (sys_rst || mode_q == MODE_RESET) begin
         functional_error_flag_q <= 1'b0;
      end else if (func_error_evt) begin
         functional_error_flag_q <= 1'b1;
      end else if (mode_q == MODE_LIMP && ar_tick) begin
         functional_error_flag_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Buck enables

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         buck1_en_q <= 1'b0;
         buck2_en_q <= 1'b0;
      end else begin
         unique case (mode_q)
            MODE_ACTIVE: begin
               buck1_en_q <= buck_drive(buck1_sel_q, pwm1_in, dim_q);
               buck2_en_q <= buck_drive(buck2_sel_q, pwm2_in, dim_q);
            end
            MODE_LIMP: begin
               buck1_en_q <= dim_q;
               buck2_en_q <= 1'b0;
            end
            default: begin
               buck1_en_q <= 1'b0;
               buck2_en_q <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode status

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         serial_active_q  <= 1'b0;
         rail_above_por_q <= 1'b0;
         low_power_q      <= 1'b1;
         regs_default_q   <= 1'b1;
      end else begin
         serial_active_q  <= (mode_q == MODE_PRESTBY) ||
                             (mode_q == MODE_LIMP) ||
                             (mode_q == MODE_ACTIVE);
         rail_above_por_q <= (mode_q != MODE_STANDBY);
         low_power_q      <= (mode_q == MODE_STANDBY);
         regs_default_q   <= (mode_q == MODE_RESET);
      end
   end

endmodule

// file: test/ldmc_mode_ctrl_monitor.sv
`timescale 1ns/100ps
module ldmc_mode_ctrl_monitor
   import ldmc_pkg::*;
(
   // Clock, reset, pins and internal events
   input wire logic       core_clk,
   input wire logic       sys_rst,
   input wire logic       chip_select_n,
   input wire logic       dim_in,
   input wire logic       watchdog_fail,
   input wire logic       pwm1_in,
   // Mode and buck outputs
   input wire ldmc_mode_e mode_q,
   input wire logic       serial_active_q,
   input wire logic       rail_above_por_q,
   input wire logic       low_power_q,
   input wire logic       regs_default_q,
   input wire logic [1:0] buck1_sel_q,
   input wire logic [1:0] buck2_sel_q,
   input wire logic       buck1_en_q,
   input wire logic       buck2_en_q
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
////////////////////////////////////////////////////////////////////////
   sequence s_left(ldmc_mode_e m);
      $past(mode_q) == m && mode_q != m;
   endsequence
   sequence s_in(ldmc_mode_e m);
      (mode_q == m)[*2];
   endsequence
   sequence s_dwell;
      (mode_q == MODE_RESET)[*8] ##1 (mode_q == MODE_RESET)[*7];
   endsequence
////////////////////////////////////////////////////////////////////////
   property p_wake;
      s_left(MODE_STANDBY) |->
         mode_q == MODE_RESET && $past(dim_in | !chip_select_n, 3);
   endproperty
   a_wake: assert property (p_wake) else $error("bad standby exit");
   property p_quiet;
      s_in(MODE_STANDBY) |->
         low_power_q && !serial_active_q && !rail_above_por_q;
   endproperty
   a_quiet: assert property (p_quiet) else $error("standby not quiet");
   property p_pre;
      s_in(MODE_PRESTBY) |-> !buck1_en_q && !buck2_en_q &&
         serial_active_q && rail_above_por_q;
   endproperty
   a_pre: assert property (p_pre) else $error("bad pre-standby");
   property p_sleep;
      s_left(MODE_PRESTBY) |->
         mode_q == MODE_STANDBY && $past(chip_select_n && !dim_in, 3);
   endproperty
   a_sleep: assert property (p_sleep) else $error("bad sleep");
   property p_rst;
      s_in(MODE_RESET) |-> regs_default_q && !serial_active_q &&
         buck1_sel_q == SEL_DIM && buck2_sel_q == SEL_OFF;
   endproperty
   a_rst: assert property (p_rst) else $error("reset not default");
   property p_dwell;
      mode_q == MODE_RESET && $past(mode_q) != MODE_RESET |->
         s_dwell ##[1:2] mode_q == MODE_LIMP;
   endproperty
   a_dwell: assert property (p_dwell) else $error("bad reset dwell");
   property p_wd;
      mode_q == MODE_ACTIVE && watchdog_fail |=> mode_q == MODE_RESET;
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog ignored");
   property p_limp;
      (mode_q == MODE_LIMP && $stable(dim_in))[*5] |->
         buck1_en_q == dim_in && !buck2_en_q;
   endproperty
   a_limp: assert property (p_limp) else $error("bad limp bucks");
   property p_act;
      (mode_q == MODE_ACTIVE && $stable({buck1_sel_q, pwm1_in, dim_in}))[*5]
         |-> serial_active_q && buck1_en_q == (buck1_sel_q[1] ?
         (buck1_sel_q[0] ? dim_in : 1'b1) : (buck1_sel_q[0] & pwm1_in));
   endproperty
   a_act: assert property (p_act) else $error("bad active buck");
endmodule

bind ldmc_mode_ctrl ldmc_mode_ctrl_monitor i_mon (
   .core_clk(core_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
   .dim_in(dim_in), .watchdog_fail(watchdog_fail), .pwm1_in(pwm1_in),
   .mode_q(mode_q), .serial_active_q(serial_active_q),
   .rail_above_por_q(rail_above_por_q), .low_power_q(low_power_q),
   .regs_default_q(regs_default_q), .buck1_sel_q(buck1_sel_q),
   .buck2_sel_q(buck2_sel_q), .buck1_en_q(buck1_en_q),
   .buck2_en_q(buck2_en_q));

// file: test/ldmc_host_model.sv
`timescale 1ns/100ps
module ldmc_host_model
   import ldmc_pkg::*;
(
   // Reset and link clock
   input  wire logic        sys_rst,
   output      logic        link_clk,
   // Frame side
   output      logic        frame_valid,
   output      logic [1:0]  frame_addr,
   output      logic [23:0] frame_data,
   input  wire logic        frame_busy_q
);
   logic run;
   int   host_err;
   initial begin
      link_clk = 1'b0;
      run = 1'b0;
      frame_valid = 1'b0;
      frame_addr = 2'h0;
      frame_data = 24'h000000;
      host_err = 0;
   end
   // Link clock runs only in reset or around a frame
   always begin
      #6;
      link_clk = (run | sys_rst) ? ~link_clk : 1'b0;
   end
   task automatic send(input logic [1:0] a, input logic [23:0] d);
      int n;
      run = 1'b1;
      repeat (4) @(posedge link_clk);
      #1;
      frame_valid = 1'b1;
      frame_addr = a;
      frame_data = d;
      @(posedge link_clk);
      #1;
      frame_valid = 1'b0;
      frame_addr = ~a;
      frame_data = ~d;
      @(posedge link_clk);
      n = 0;
      while (frame_busy_q !== 1'b0 && n < 64) begin
         @(posedge link_clk);
         n++;
      end
      if (n == 64) begin
         host_err++;
         $display("ERROR t=%0t busy=%h exp=%h", $time, frame_busy_q, 1'b0);
      end
      run = 1'b0;
   endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import ldmc_pkg::*;
   logic        core_clk, sys_rst, link_clk, frame_valid, frame_busy_q;
   logic [1:0]  frame_addr, b1sel;
   logic [23:0] frame_data;
   logic        chip_select_n, dim_in, uv, wd, fe, pwm1, pwm2;
   logic        ser_act, lowp, fe_flag, b1en, b2en;
   ldmc_mode_e  mode_q;
   int          err_count, checks_done, n;

   always #12.5 core_clk = ~core_clk;

   ldmc_host_model i_ldmc_host_model (.sys_rst(sys_rst), .link_clk(link_clk),
      .frame_valid(frame_valid), .frame_addr(frame_addr),
      .frame_data(frame_data), .frame_busy_q(frame_busy_q));
   ldmc_mode_ctrl #(.WAKE_HOLD_CYC(5), .STBY_DELAY_CYC(8),
      .AUTORESTART_CYC(20)) i_ldmc_mode_ctrl (
      .core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk),
      .frame_valid(frame_valid), .frame_addr(frame_addr),
      .frame_data(frame_data), .frame_busy_q(frame_busy_q),
      .chip_select_n(chip_select_n), .dim_in(dim_in),
      .serial_supply_uv(uv), .watchdog_fail(wd), .func_error_evt(fe),
      .pwm1_in(pwm1), .pwm2_in(pwm2), .mode_q(mode_q),
      .serial_active_q(ser_act), .rail_above_por_q(), .low_power_q(lowp),
      .regs_default_q(), .functional_error_flag_q(fe_flag),
      .buck1_sel_q(b1sel), .buck2_sel_q(), .buck1_en_q(b1en),
      .buck2_en_q(b2en));
////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      err_count += i_ldmc_host_model.host_err;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask
   task automatic wait_mode(input ldmc_mode_e m, input int lim);
      n = 0;
      while (mode_q !== m && n < lim) begin
         cyc(1);
         n++;
      end
      chk(mode_q, m);
      if (mode_q !== m) give_verdict();
   endtask
   task automatic seq2(input logic [23:0] d);
      i_ldmc_host_model.send(FR_CTRL1, 24'h000002);
      i_ldmc_host_model.send(FR_CTRL2, d);
   endtask
   task automatic to_active();
      seq2(24'h000004);
      wait_mode(MODE_ACTIVE, 10);
   endtask
   task automatic back_limp(input ldmc_mode_e first);
      wait_mode(first, 10);
      wait_mode(MODE_LIMP, 30);
   endtask
////////////////////////////////////////////////////////////////////////
   task automatic t_wake();
      dim_in = 1'b1;
      cyc(3);
      dim_in = 1'b0;
      cyc(10);
      chk(mode_q, MODE_STANDBY);
      chip_select_n = 1'b0;
      wait_mode(MODE_RESET, 20);
      n = 0;
      while (mode_q === MODE_RESET && n < 40) begin
         cyc(1);
         n++;
      end
      chk(n, 16);
      chk(mode_q, MODE_LIMP);
      chip_select_n = 1'b1;
   endtask
   task automatic t_limp();
      dim_in = 1'b1;
      cyc(5);
      chk(b1en, 1'b1);
      chk(b2en, 1'b0);
      dim_in = 1'b0;
      cyc(5);
      chk(b1en, 1'b0);
      i_ldmc_host_model.send(FR_CTRL3, 24'h00A000);
      i_ldmc_host_model.send(FR_CTRL2, 24'h000000);
      cyc(4);
      chk(b1sel, SEL_DIM);
      chk(mode_q, MODE_LIMP);
      fe = 1'b1;
      cyc(1);
      chk(fe_flag, 1'b1);
      fe = 1'b0;
      n = 0;
      while (fe_flag === 1'b1 && n < 22) begin
         cyc(1);
         n++;
      end
      chk(fe_flag, 1'b0);
      i_ldmc_host_model.send(FR_CTRL1, 24'h000002);
      i_ldmc_host_model.send(FR_CTRL1, 24'h000000);
      i_ldmc_host_model.send(FR_CTRL2, 24'h000004);
      i_ldmc_host_model.send(FR_CTRL1, 24'h000001);
      i_ldmc_host_model.send(FR_CTRL2, 24'h000004);
      cyc(4);
      chk(mode_q, MODE_LIMP);
   endtask
   task automatic t_active();
      for (int k = 0; k < 8; k++) begin
         cyc(1);
         pwm1 = k[2];
         dim_in = ~k[2];
         i_ldmc_host_model.send(FR_CTRL3, {8'h00, k[1:0], 14'h0000});
         cyc(8);
         chk(b1sel, k[1:0]);
         chk(b1en, k[1:0] == SEL_ON || (k[1:0] == SEL_PWM && pwm1) ||
            (k[1:0] == SEL_DIM && dim_in));
         chk(ser_act, 1'b1);
      end
      pwm1 = 1'b0;
      pwm2 = 1'b1;
      i_ldmc_host_model.send(FR_CTRL3, 24'h001000);
      cyc(8);
      chk(b1sel, SEL_OFF);
      chk(b1en, 1'b0);
      chk(b2en, 1'b1);
      pwm2 = 1'b0;
      i_ldmc_host_model.send(FR_CTRL2, 24'h000000);
      back_limp(MODE_RESET);
      chk(b1sel, SEL_DIM);
      to_active();
      seq2(24'h00000C);
      back_limp(MODE_RESET);
      to_active();
      cyc(1);
      wd = 1'b1;
      cyc(1);
      wd = 1'b0;
      back_limp(MODE_RESET);
      to_active();
      cyc(1);
      uv = 1'b1;
      wait_mode(MODE_RESET, 10);
      uv = 1'b0;
      wait_mode(MODE_LIMP, 30);
   endtask
   task automatic t_prestby();
      cyc(1);
      dim_in = 1'b1;
      seq2(24'h000008);
      wait_mode(MODE_PRESTBY, 10);
      cyc(20);
      chk(mode_q, MODE_PRESTBY);
      chk(b1en, 1'b0);
      chk(ser_act, 1'b1);
      dim_in = 1'b0;
      wait_mode(MODE_STANDBY, 20);
   endtask
////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      chip_select_n = 1'b1;
      dim_in = 1'b0;
      uv = 1'b0;
      wd = 1'b0;
      fe = 1'b0;
      pwm1 = 1'b0;
      pwm2 = 1'b0;
      err_count = 0;
      checks_done = 0;
      repeat (6) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      cyc(2);
      chk(mode_q, MODE_STANDBY);
      chk(lowp, 1'b1);
      t_wake();
      t_limp();
      to_active();
      t_active();
      t_prestby();
      seq2(24'h000004);
      cyc(4);
      chk(mode_q, MODE_STANDBY);
      t_wake();
      to_active();
      t_prestby();
      t_wake();
      sys_rst = 1'b1;
      cyc(3);
      sys_rst = 1'b0;
      cyc(1);
      chk(mode_q, MODE_STANDBY);
      give_verdict();
   end
endmodule
